// ### verilog/usb_power_and_interrupt_regs.sv
// Operation
// RULE1 - Suspend power-down disables transceiver while suspended
// RULE2 - Host software or peripheral hardware sets suspend
// RULE3 - Common flag read or wake-up clears suspend
// RULE4 - Software holds resume about 10 ms
// RULE5 - Host hardware sets resume on peripheral resume
// RULE6 - Bus reset bit holds until idle
// RULE7 - Bus reset writable host, read-only peripheral
// RULE8 - Soft connect selects drive, clear after reset
// RULE9 - Iso update holds packet until SOF
// RULE10 - Tx flags: control bit0, tx 1-3
// RULE11 - Rx flags: rx 1-3, bit0 reserved
// RULE12 - Unconfigured endpoint bits read as zero
// RULE13 - Flag register read returns then clears flags
// RULE14 - Tx enable gates bitwise, resets 000Fh
// RULE15 - Rx enable gates bits 1-3, resets 000Eh
// RULE16 - Common flags hold eight fixed events
// RULE17 - Suspend flag peripheral, resume flag when suspended
// RULE18 - Reset-or-babble flag per mode
// RULE19 - Start-of-frame flag each frame
// RULE20 - Connect host only, disconnect per mode
// RULE21 - Session request, bus power error A only
// RULE22 - Common enable register resets to 06h
// RULE23 - Interrupt on any enabled set flag
`timescale 1ns/1ps
`include "usb_pwr_cfg.svh"
module usb_power_and_interrupt_regs #(
  parameter usb_pwr_pkg::ep_vec_t TX_MASK = `TX_EP_MASK,
  parameter usb_pwr_pkg::ep_vec_t RX_MASK = `RX_EP_MASK
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire usb_pwr_pkg::reg_index_t avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire usb_pwr_pkg::bus_word_t avsWritedata,
  input wire logic [3:0] avsByteenable,
  output usb_pwr_pkg::bus_word_t avsReaddata,
  output logic avsWaitrequest,
  input wire logic hostMode,
  input wire logic aDevice,
  input wire logic suspendDetect,
  input wire logic resumeDetect,
  input wire logic resetSignalling,
  input wire logic busIdle,
  input wire logic babbleDetect,
  input wire logic sofEvent,
  input wire logic connectDetect,
  input wire logic disconnectDetect,
  input wire logic sessionEnd,
  input wire logic sessionRequestDetect,
  input wire logic busPowerDrop,
  input wire usb_pwr_pkg::ep_vec_t txEndpointEvent,
  input wire usb_pwr_pkg::ep_vec_t rxEndpointEvent,
  input wire logic isoTxPacketReady,
  input wire logic sofToken,
  input wire logic inToken,
  output logic usbIrq,
  output logic transceiverEnable,
  output logic transceiverDrive,
  output logic driveResume,
  output logic driveBusReset,
  output logic isoHoldPacket,
  output logic isoZeroLength
);
  import usb_pwr_pkg::*;

  // Match of the bus address against one register index
  function automatic logic regHit(input reg_index_t addr,
                                  input reg_index_t idx);
    regHit = (addr == idx);
  endfunction : regHit

  // Byte-lane merge for the 16-bit enable registers
  function automatic ep_vec_t laneMerge(input ep_vec_t old,
                                        input bus_word_t wd,
                                        input logic [3:0] be);
    laneMerge = {be[1] ? wd[15:8] : old[15:8],
                 be[0] ? wd[7:0] : old[7:0]};
  endfunction : laneMerge

  // Bus handshake state
  logic ack_reg;
  logic ack_next;
  bus_word_t readData_reg;
  bus_word_t readData_next;

  // Power control bits
  logic suspendPd_reg;
  logic suspendState_reg;
  logic suspendState_next;
  logic resume_reg;
  logic resume_next;
  logic busReset_reg;
  logic busReset_next;
  logic softConnect_reg;
  logic iso_update_mode_reg;

  // Enable registers
  ep_vec_t txEnable_reg;
  ep_vec_t rxEnable_reg;
  common_vec_t commonEnable_reg;

  // Flag vectors from the sticky flag blocks
  ep_vec_t txFlags;
  ep_vec_t rxFlags;
  common_vec_t commonFlags;

  // Iso update sequencer
  iso_state_t isoState_reg;
  iso_state_t isoState_next;
  logic isoZero_reg;
  logic isoZero_next;

  // Reset edge detector for the peripheral reset event
  logic resetSeen_reg;

  // Decoded bus strobes
  wire reqActive = avsRead | avsWrite;
  wire readTaken = avsRead & ack_reg;
  wire writeTaken = avsWrite & ack_reg;
  wire lowLane = avsByteenable[0];
  wire hitPower = regHit(avsAddress, `IDX_POWER);
  wire hitTxFlags = regHit(avsAddress, `IDX_TX_FLAGS);
  wire hitRxFlags = regHit(avsAddress, `IDX_RX_FLAGS);
  wire hitTxEn = regHit(avsAddress, `IDX_TX_ENABLE);
  wire hitRxEn = regHit(avsAddress, `IDX_RX_ENABLE);
  wire hitCmnFlags = regHit(avsAddress, `IDX_COMMON_FLAGS);
  wire hitCmnEn = regHit(avsAddress, `IDX_COMMON_ENABLE);
  wire powerWr = writeTaken & hitPower & lowLane;

  // One wait cycle, then the request is taken
  assign ack_next = reqActive & ~ack_reg;
  assign avsWaitrequest = reqActive & ~ack_reg;
  assign avsReaddata = readData_reg;

  // Power register image; reserved bit 4 reads zero
  wire [7:0] powerImage = `PWR_RSVD_READ |
    {iso_update_mode_reg, softConnect_reg, 2'b00, busReset_reg,
     resume_reg, suspendState_reg, suspendPd_reg};

  // Read selection; unmapped addresses read as zero
  always_comb begin
    readData_next = '0;
    if (hitPower) begin
      readData_next[7:0] = powerImage;
    end else if (hitTxFlags) begin
      readData_next[15:0] = txFlags;
    end else if (hitRxFlags) begin
      readData_next[15:0] = rxFlags;
    end else if (hitTxEn) begin
      readData_next[15:0] = txEnable_reg;
    end else if (hitRxEn) begin
      readData_next[15:0] = rxEnable_reg;
    end else if (hitCmnFlags) begin
      readData_next[7:0] = commonFlags;
    end else if (hitCmnEn) begin
      readData_next[7:0] = commonEnable_reg;
    end
  end

  // Bus handshake and read capture in the wait cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg <= 1'b0;
      readData_reg <= '0;
    end else begin
      ack_reg <= ack_next;
      if (avsRead && !ack_reg) begin
        readData_reg <= readData_next;
      end
    end
  end

  // Clear only the bits handed out, so a later event is kept
  // RULE13 clear on read
  wire [15:0] txClear = (readTaken && hitTxFlags) ?
    readData_reg[15:0] : 16'h0000;
  wire [15:0] rxClear = (readTaken && hitRxFlags) ?
    readData_reg[15:0] : 16'h0000;
  wire [7:0] cmnClear = (readTaken && hitCmnFlags) ?
    readData_reg[7:0] : 8'h00;

  // Suspend state sources
  // RULE2 suspend set sources
  wire suspHwSet = ~hostMode & suspendDetect;
  wire suspSwWr = powerWr & hostMode;
  // RULE3 suspend clear causes
  wire suspClrRead = cmnClear[`CMN_SUSPEND];
  wire suspClrWake = powerWr & avsWritedata[`PWR_RESUME] & ~resume_reg;

  // Hardware entry wins over every clear
  always_comb begin
    suspendState_next = suspendState_reg;
    if (suspHwSet) begin
      suspendState_next = 1'b1;
    end else if (suspClrWake) begin
      suspendState_next = 1'b0;
    end else if (suspSwWr) begin
      suspendState_next = avsWritedata[`PWR_SUSPEND_STATE];
    end else if (suspClrRead) begin
      suspendState_next = 1'b0;
    end
  end

  // Resume bit; the hold time is software's job, not timed here
  // RULE5 host resume detect
  wire resumeHwSet = hostMode & resumeDetect & suspendState_reg;
  assign resume_next = resumeHwSet ? 1'b1 :
    (powerWr ? avsWritedata[`PWR_RESUME] : resume_reg);

  // Bus reset bit: software writes only in host mode
  always_comb begin
    busReset_next = busReset_reg;
    // RULE6 set and hold
    if (resetSignalling) begin
      busReset_next = 1'b1;
    // RULE7 host-only write
    end else if (powerWr && hostMode) begin
      busReset_next = avsWritedata[`PWR_BUS_RESET];
    end else if (!hostMode && busIdle) begin
      busReset_next = 1'b0;
    end
  end

  // Power register storage
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      suspendPd_reg <= 1'b0;
      suspendState_reg <= 1'b0;
      resume_reg <= 1'b0;
      busReset_reg <= 1'b0;
      softConnect_reg <= 1'b0;
      iso_update_mode_reg <= 1'b0;
      resetSeen_reg <= 1'b0;
    end else begin
      suspendState_reg <= suspendState_next;
      resume_reg <= resume_next;
      busReset_reg <= busReset_next;
      resetSeen_reg <= resetSignalling;
      if (powerWr) begin
        suspendPd_reg <= avsWritedata[`PWR_SUSPEND_PD];
        softConnect_reg <= avsWritedata[`PWR_SOFT_CONNECT];
        iso_update_mode_reg <= avsWritedata[`PWR_ISO_UPDATE];
      end
    end
  end

  // Transceiver controls
  // RULE1 power down in suspend
  assign transceiverEnable = ~(suspendPd_reg & suspendState_reg);
  // RULE8 soft connect drive
  assign transceiverDrive = hostMode | softConnect_reg;
  assign driveResume = resume_reg;
  assign driveBusReset = hostMode & busReset_reg;

  // Enable registers; unconfigured bits never store
  // RULE14 tx enable reset
  // RULE15 rx enable reset
  // RULE22 common enable reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      txEnable_reg <= `TX_ENABLE_RESET & TX_MASK;
      rxEnable_reg <= `RX_ENABLE_RESET & RX_MASK;
      commonEnable_reg <= `COMMON_ENABLE_RESET;
    end else begin
      // RULE12 masked enables
      if (writeTaken && hitTxEn) begin
        txEnable_reg <= laneMerge(txEnable_reg, avsWritedata,
                                  avsByteenable) & TX_MASK;
      end
      if (writeTaken && hitRxEn) begin
        rxEnable_reg <= laneMerge(rxEnable_reg, avsWritedata,
                                  avsByteenable) & RX_MASK;
      end
      if (writeTaken && hitCmnEn && lowLane) begin
        commonEnable_reg <= avsWritedata[7:0];
      end
    end
  end

  // Common event sources, qualified by mode, A device or suspend state; SOF is not qualified
  common_vec_t cmnSet;
  always_comb begin
    cmnSet = '0;
    // RULE17 suspend and resume
    cmnSet[`CMN_SUSPEND] = suspendDetect & ~hostMode;
    cmnSet[`CMN_RESUME] = resumeDetect & suspendState_reg;
    // RULE18 babble or reset
    cmnSet[`CMN_RESET_BABBLE] = hostMode ? babbleDetect :
      (resetSignalling & ~resetSeen_reg);
    // RULE19 frame start
    cmnSet[`CMN_SOF] = sofEvent;
    // RULE20 connect and disconnect
    cmnSet[`CMN_CONNECT] = connectDetect & hostMode;
    cmnSet[`CMN_DISCONNECT] = hostMode ? disconnectDetect : sessionEnd;
    // RULE21 A device events
    cmnSet[`CMN_SESSION_REQ] = sessionRequestDetect & aDevice;
    cmnSet[`CMN_BUS_POWER_ERR] = busPowerDrop & aDevice;
  end

  // RULE10 tx flag layout
  // RULE12 masked tx flags
  usb_event_flags #(.WIDTH(16), .MASK(TX_MASK)) txFlagBlock (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .setPulse(txEndpointEvent),
    .clearMask(txClear),
    .flags(txFlags)
  );

  // RULE11 rx flag layout
  usb_event_flags #(.WIDTH(16), .MASK(RX_MASK)) rxFlagBlock (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .setPulse(rxEndpointEvent),
    .clearMask(rxClear),
    .flags(rxFlags)
  );

  // RULE16 common flag layout
  usb_event_flags #(.WIDTH(8), .MASK(8'hFF)) cmnFlagBlock (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .setPulse(cmnSet),
    .clearMask(cmnClear),
    .flags(commonFlags)
  );

  // RULE23 combined interrupt
  assign usbIrq = |(txFlags & txEnable_reg) |
    |(rxFlags & rxEnable_reg) | |(commonFlags & commonEnable_reg);

  // Iso update applies only to a peripheral with the mode set
  wire isoActive = iso_update_mode_reg & ~hostMode;

  // Iso sequencer next state
  // RULE9 hold until SOF
  always_comb begin
    isoState_next = isoState_reg;
    isoZero_next = 1'b0;
    case (isoState_reg)
      ISO_IDLE: begin
        if (isoActive && isoTxPacketReady) begin
          isoState_next = ISO_WAIT_SOF;
        end
      end
      ISO_WAIT_SOF: begin
        // Packet withdrawn or mode dropped
        if (!isoActive || !isoTxPacketReady) begin
          isoState_next = ISO_IDLE;
        end else if (sofToken) begin
          isoState_next = ISO_READY;
        end else if (inToken) begin
          isoZero_next = 1'b1;
        end
      end
      ISO_READY: begin
        // Packet sent clears ready, then we rearm
        if (!isoActive || !isoTxPacketReady) begin
          isoState_next = ISO_IDLE;
        end
      end
      default: begin
        isoState_next = ISO_IDLE;
      end
    endcase
  end

  // Iso sequencer storage
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      isoState_reg <= ISO_IDLE;
      isoZero_reg <= 1'b0;
    end else begin
      isoState_reg <= isoState_next;
      isoZero_reg <= isoZero_next;
    end
  end

  assign isoHoldPacket = (isoState_reg == ISO_WAIT_SOF);
  assign isoZeroLength = isoZero_reg;

  // Checks on the block's own behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_isoWaiting;
    isoHoldPacket && isoActive && isoTxPacketReady;
  endsequence
  sequence s_inBeforeSof;
    s_isoWaiting ##0 (inToken && !sofToken);
  endsequence

  a_bus_wait_once: assert property ( // bus handshake
    (reqActive && avsWaitrequest) |=> (ack_reg && !avsWaitrequest))
    else $error("request not answered after one wait cycle");
  a_xcvr_power_down: assert property ( // RULE1
    (suspendPd_reg && $rose(suspendState_reg)) |-> !transceiverEnable)
    else $error("transceiver left enabled in suspend");
  a_soft_connect: assert property ( // RULE8
    (!hostMode && !softConnect_reg) |-> !transceiverDrive)
    else $error("peripheral drives lines while disconnected");
  a_flag_read_clear: assert property ( // RULE13
    (readTaken && hitCmnFlags && cmnSet == 8'h00)
    |=> ((commonFlags & $past(readData_reg[7:0])) == 8'h00))
    else $error("common flags not cleared by read");
  a_suspend_read_clr: assert property ( // RULE3
    (suspClrRead && !suspHwSet && !suspSwWr) |=> !suspendState_reg)
    else $error("suspend state not cleared by flag read");
  a_resume_hw_set: assert property ( // RULE5
    resumeHwSet |=> resume_reg)
    else $error("host resume detect did not set resume");
  a_reset_hold: assert property ( // RULE6
    (busReset_reg && !busIdle && !(powerWr && hostMode))
    |=> busReset_reg)
    else $error("bus reset bit dropped before idle");
  a_irq_enabled: assert property ( // RULE23
    (|(commonFlags & commonEnable_reg)) |-> usbIrq)
    else $error("enabled common flag without interrupt");
  a_iso_zero_len: assert property ( // RULE9
    s_inBeforeSof |=> (isoZeroLength ##1 !isoZeroLength))
    else $error("no zero-length packet before SOF");
  a_unconfig_zero: assert property ( // RULE12
    ((txFlags & ~TX_MASK) == 16'h0000) &&
    ((rxEnable_reg & ~RX_MASK) == 16'h0000))
    else $error("unconfigured endpoint bit set");
endmodule : usb_power_and_interrupt_regs

// ### verilog/usb_pwr_cfg.svh
`ifndef USB_PWR_CFG_SVH
`define USB_PWR_CFG_SVH

// Register word indices; byte address is four times the index
`define IDX_POWER 4'h0
`define IDX_TX_FLAGS 4'h1
`define IDX_RX_FLAGS 4'h2
`define IDX_TX_ENABLE 4'h3
`define IDX_RX_ENABLE 4'h4
`define IDX_COMMON_FLAGS 4'h5
`define IDX_COMMON_ENABLE 4'h6

// Power control field positions
`define PWR_SUSPEND_PD 0
`define PWR_SUSPEND_STATE 1
`define PWR_RESUME 2
`define PWR_BUS_RESET 3
`define PWR_SOFT_CONNECT 6
`define PWR_ISO_UPDATE 7

// Reserved power bit that reads back at its reset level
`define PWR_RSVD_READ 8'h20

// Common event field positions
`define CMN_SUSPEND 0
`define CMN_RESUME 1
`define CMN_RESET_BABBLE 2
`define CMN_SOF 3
`define CMN_CONNECT 4
`define CMN_DISCONNECT 5
`define CMN_SESSION_REQ 6
`define CMN_BUS_POWER_ERR 7

// Reset values and configured endpoint masks
`define TX_ENABLE_RESET 16'h000F
`define RX_ENABLE_RESET 16'h000E
`define COMMON_ENABLE_RESET 8'h06
`define TX_EP_MASK 16'h000F
`define RX_EP_MASK 16'h000E

`endif

// ### verilog/usb_pwr_pkg.sv
package usb_pwr_pkg;
  // Avalon data word
  typedef logic [31:0] bus_word_t;
  // Register index on the word-addressed bus
  typedef logic [3:0] reg_index_t;
  // Endpoint flag and enable vector
  typedef logic [15:0] ep_vec_t;
  // Common event vector
  typedef logic [7:0] common_vec_t;
  // Isochronous update sequencing
  typedef enum logic [1:0] {
    ISO_IDLE,
    ISO_WAIT_SOF,
    ISO_READY
  } iso_state_t;
endpackage : usb_pwr_pkg

// ### verilog/usb_event_flags.sv
`timescale 1ns/1ps
module usb_event_flags #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] MASK = '1
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] setPulse,
  input wire logic [WIDTH-1:0] clearMask,
  output logic [WIDTH-1:0] flags
);
  // Sticky flags, unconfigured bits forced low
  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // A set in the clearing cycle survives the clear
  assign flags_next = ((flags_reg & ~clearMask) | setPulse) & MASK;
  assign flags = flags_reg;

  // Flag storage
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end
endmodule : usb_event_flags

// ### bench/usb_far_side_model.sv
`timescale 1ns/1ps
module usb_far_side_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic evReq,
  input wire logic [3:0] evSel,
  output logic [10:0] pulses,
  output logic resetLevel,
  output logic busIdle
);
  // Codes 0 to 10 give a one-cycle event, 14 starts bus reset, 15 ends it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulses <= '0;
      resetLevel <= 1'b0;
      busIdle <= 1'b1;
    end else begin
      // One cycle only, so each request counts as exactly one event
      pulses <= evReq ? (11'h001 << evSel) : 11'h000;
      if (evReq && evSel == 4'hE) begin
        resetLevel <= 1'b1;
        busIdle <= 1'b0;
      end else if (evReq && evSel == 4'hF) begin
        resetLevel <= 1'b0;
        busIdle <= 1'b1;
      end
    end
  end
endmodule : usb_far_side_model

// ### bench/testbench.sv
`timescale 1ns/1ps
`include "usb_pwr_cfg.svh"
module testbench;
  import usb_pwr_pkg::*;
  // Host, A device, event code, expected common flags
  localparam logic [13:0] CMN_TAB [11] = '{14'h0308, 14'h2204, 14'h2410,
    14'h0400, 14'h2520, 14'h0620, 14'h1740, 14'h0700, 14'h1880,
    14'h0800, 14'h2000};
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  reg_index_t avsAddress = '0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  bus_word_t avsWritedata = '0;
  logic [3:0] avsByteenable = 4'hF;
  bus_word_t avsReaddata;
  logic avsWaitrequest;
  logic hostMode = 1'b0;
  logic aDevice = 1'b0;
  ep_vec_t txEndpointEvent = '0;
  ep_vec_t rxEndpointEvent = '0;
  logic isoTxPacketReady = 1'b0;
  logic evReq = 1'b0;
  logic [3:0] evSel = 4'h0;
  logic [10:0] pulses;
  logic rstLvl, idle, usbIrq, transceiverEnable, transceiverDrive;
  logic driveResume, driveBusReset, isoHoldPacket, isoZeroLength;
  int err_count = 0;
  int compares = 0;
  int zlCount = 0;
  bus_word_t rd;

  usb_power_and_interrupt_regs u_dut (
    .ref_clk, .arst_n, .avsAddress, .avsRead, .avsWrite, .avsWritedata,
    .avsByteenable, .avsReaddata, .avsWaitrequest, .hostMode, .aDevice,
    .suspendDetect(pulses[0]), .resumeDetect(pulses[1]),
    .resetSignalling(rstLvl), .busIdle(idle), .babbleDetect(pulses[2]),
    .sofEvent(pulses[3]), .connectDetect(pulses[4]),
    .disconnectDetect(pulses[5]), .sessionEnd(pulses[6]),
    .sessionRequestDetect(pulses[7]), .busPowerDrop(pulses[8]),
    .txEndpointEvent, .rxEndpointEvent, .isoTxPacketReady,
    .sofToken(pulses[9]), .inToken(pulses[10]), .usbIrq,
    .transceiverEnable, .transceiverDrive, .driveResume, .driveBusReset,
    .isoHoldPacket, .isoZeroLength
  );
  usb_far_side_model u_far (.ref_clk, .arst_n, .evReq, .evSel, .pulses,
    .resetLevel(rstLvl), .busIdle(idle));

  // Free-running clock
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // Counted at the falling edge so a one-cycle pulse is seen once
  always @(negedge ref_clk) begin
    if (isoZeroLength === 1'b1) zlCount++;
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk_w(input string n, input bus_word_t e,
                       input bus_word_t s);
    compares++;
    if (e !== s) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk_w

  task automatic chk_b(input string n, input logic e, input logic s);
    compares++;
    if (e !== s) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", n, e, s);
    end
  endtask : chk_b

  // Avalon cycle: waitrequest is sampled at each rising edge; the edge
  // that sees it low completes the transfer and hands back read data
  task automatic bus(input logic wr, input reg_index_t a,
                     input bus_word_t d, output bus_word_t q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avsAddress <= a;
    avsWritedata <= d;
    avsRead <= !wr;
    avsWrite <= wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 20);
    if (avsWaitrequest !== 1'b0) begin
      err_count++;
      report_and_stop();
    end
    q = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask : bus

  task automatic wr(input reg_index_t a, input bus_word_t d);
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rchk(input string n, input reg_index_t a,
                      input bus_word_t e);
    bus(1'b0, a, '0, rd);
    chk_w(n, e, rd);
  endtask : rchk

  // One far-side event, then time for the flag to land
  task automatic fire(input logic [3:0] s);
    @(posedge ref_clk);
    evSel <= s;
    evReq <= 1'b1;
    @(posedge ref_clk);
    evReq <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : fire

  task automatic epev(input ep_vec_t t, input ep_vec_t r);
    @(posedge ref_clk);
    txEndpointEvent <= t;
    rxEndpointEvent <= r;
    @(posedge ref_clk);
    txEndpointEvent <= '0;
    rxEndpointEvent <= '0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : epev

  task automatic t_reset();
    rchk("pwr", `IDX_POWER, 32'h00000020);
    rchk("txen", `IDX_TX_ENABLE, 32'h0000000F);
    rchk("rxen", `IDX_RX_ENABLE, 32'h0000000E);
    rchk("cmnen", `IDX_COMMON_ENABLE, 32'h00000006);
    rchk("cmn", `IDX_COMMON_FLAGS, 32'h00000000);
    wr(4'h9, 32'hFFFFFFFF);
    rchk("unmapped", 4'h9, 32'h00000000);
    chk_b("drive", 1'b0, transceiverDrive);
    chk_b("irq", 1'b0, usbIrq);
    $display("test reset done");
  endtask : t_reset

  task automatic t_endpoint();
    epev(16'hFFFF, 16'hFFFF);
    chk_b("irq", 1'b1, usbIrq);
    wr(`IDX_TX_FLAGS, 32'h00000000);
    rchk("txf", `IDX_TX_FLAGS, 32'h0000000F);
    rchk("txf2", `IDX_TX_FLAGS, 32'h00000000);
    rchk("rxf", `IDX_RX_FLAGS, 32'h0000000E);
    rchk("rxf2", `IDX_RX_FLAGS, 32'h00000000);
    @(negedge ref_clk);
    chk_b("irq", 1'b0, usbIrq);
    wr(`IDX_TX_ENABLE, 32'h0000FFF6);
    rchk("txen", `IDX_TX_ENABLE, 32'h00000006);
    epev(16'h0001, 16'h0000);
    chk_b("irq", 1'b0, usbIrq);
    epev(16'h0002, 16'h0000);
    chk_b("irq", 1'b1, usbIrq);
    rchk("txf", `IDX_TX_FLAGS, 32'h00000003);
    wr(`IDX_TX_ENABLE, 32'h0000000F);
    wr(`IDX_RX_ENABLE, 32'h00000000);
    epev(16'h0000, 16'h0004);
    chk_b("irq", 1'b0, usbIrq);
    rchk("rxf", `IDX_RX_FLAGS, 32'h00000004);
    wr(`IDX_RX_ENABLE, 32'h0000000E);
    // Upper lane only: low byte and 8-bit registers stay put
    avsByteenable <= 4'h2;
    wr(`IDX_TX_ENABLE, 32'h00000000);
    wr(`IDX_COMMON_ENABLE, 32'h000000FF);
    avsByteenable <= 4'hF;
    rchk("txenlane", `IDX_TX_ENABLE, 32'h0000000F);
    rchk("cmnlane", `IDX_COMMON_ENABLE, 32'h00000006);
    $display("test endpoint done");
  endtask : t_endpoint

  task automatic t_common();
    logic [13:0] e;
    for (int i = 0; i < 11; i++) begin
      e = CMN_TAB[i];
      @(posedge ref_clk);
      hostMode <= e[13];
      aDevice <= e[12];
      fire(e[11:8]);
      chk_b("cmnirq", |(e[7:0] & 8'h06), usbIrq);
      rchk("cmn", `IDX_COMMON_FLAGS, {24'h000000, e[7:0]});
      rchk("cmnclr", `IDX_COMMON_FLAGS, 32'h00000000);
    end
    $display("test common done");
  endtask : t_common

  task automatic t_suspend();
    @(posedge ref_clk);
    hostMode <= 1'b0;
    wr(`IDX_POWER, 32'h00000001);
    fire(4'h0);
    rchk("pwr", `IDX_POWER, 32'h00000023);
    chk_b("xcvr", 1'b0, transceiverEnable);
    fire(4'h1);
    rchk("cmn", `IDX_COMMON_FLAGS, 32'h00000003);
    rchk("pwr", `IDX_POWER, 32'h00000021);
    chk_b("xcvr", 1'b1, transceiverEnable);
    fire(4'h0);
    wr(`IDX_POWER, 32'h00000005);
    rchk("pwr", `IDX_POWER, 32'h00000025);
    chk_b("resume", 1'b1, driveResume);
    // Hold is timed by software only; kept short to bound the run
    repeat (50) @(posedge ref_clk);
    wr(`IDX_POWER, 32'h00000000);
    @(negedge ref_clk);
    chk_b("resume", 1'b0, driveResume);
    rchk("cmn", `IDX_COMMON_FLAGS, 32'h00000001);
    @(posedge ref_clk);
    hostMode <= 1'b1;
    wr(`IDX_POWER, 32'h00000002);
    rchk("pwr", `IDX_POWER, 32'h00000022);
    fire(4'h1);
    bus(1'b0, `IDX_POWER, '0, rd);
    chk_w("pwrres", 32'h00000004, rd & 32'h00000004);
    chk_b("resume", 1'b1, driveResume);
    wr(`IDX_POWER, 32'h00000000);
    rchk("cmn", `IDX_COMMON_FLAGS, 32'h00000002);
    $display("test suspend done");
  endtask : t_suspend

  task automatic t_busreset();
    @(posedge ref_clk);
    hostMode <= 1'b0;
    fire(4'hE);
    rchk("pwr", `IDX_POWER, 32'h00000028);
    chk_b("rstdrv", 1'b0, driveBusReset);
    wr(`IDX_POWER, 32'h00000000);
    rchk("pwr", `IDX_POWER, 32'h00000028);
    rchk("cmn", `IDX_COMMON_FLAGS, 32'h00000004);
    fire(4'hF);
    rchk("pwr", `IDX_POWER, 32'h00000020);
    @(posedge ref_clk);
    hostMode <= 1'b1;
    wr(`IDX_POWER, 32'h00000008);
    rchk("pwr", `IDX_POWER, 32'h00000028);
    chk_b("rstdrv", 1'b1, driveBusReset);
    wr(`IDX_POWER, 32'h00000000);
    rchk("pwr", `IDX_POWER, 32'h00000020);
    $display("test bus reset done");
  endtask : t_busreset

  task automatic t_soft_iso();
    @(posedge ref_clk);
    hostMode <= 1'b0;
    wr(`IDX_POWER, 32'h00000040);
    rchk("pwr", `IDX_POWER, 32'h00000060);
    chk_b("drive", 1'b1, transceiverDrive);
    wr(`IDX_POWER, 32'h00000080);
    @(negedge ref_clk);
    chk_b("drive", 1'b0, transceiverDrive);
    @(posedge ref_clk);
    isoTxPacketReady <= 1'b1;
    fire(4'hA);
    chk_b("hold", 1'b1, isoHoldPacket);
    chk_w("zl", 32'h00000001, zlCount);
    fire(4'h9);
    chk_b("hold", 1'b0, isoHoldPacket);
    fire(4'hA);
    chk_w("zl", 32'h00000001, zlCount);
    @(posedge ref_clk);
    isoTxPacketReady <= 1'b0;
    wr(`IDX_POWER, 32'h00000000);
    isoTxPacketReady <= 1'b1;
    fire(4'hA);
    chk_b("hold", 1'b0, isoHoldPacket);
    chk_w("zl", 32'h00000001, zlCount);
    @(posedge ref_clk);
    isoTxPacketReady <= 1'b0;
    $display("test soft connect and iso done");
  endtask : t_soft_iso

  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset();
    t_endpoint();
    t_common();
    t_suspend();
    t_busreset();
    t_soft_iso();
    report_and_stop();
  end
endmodule : testbench
